/* File: rtl/fosp_top.sv */
// What this block does
// - Separate projector and preview enables route frames
// - Commands still processed with outputs disabled
// - Rate readout counts preview frames only
// - Rising mode holds until low-to-high sync
// - Falling mode holds until high-to-low sync
// - Any-edge mode releases on either transition
// - Programmable delay after edge, default zero
// - Abandon sync wait after one second
// - Stall for shortfall below minimum frame period
// - Maximum frame rate programmable, default 100
// - Rate readout excludes limiter stall time
//
// Purpose: Output-stage pacer between show sequencer and frame sinks
// Assumes: One clock, synchronous reset, AXI4-Lite slave for registers
// Notes:   Sync delay register is in microseconds
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module fosp_top
  import fosp_pkg::*;
#(
  parameter int unsigned SYNC_TIMEOUT_CYC_P = SYNC_TIMEOUT_CYC,
  parameter int unsigned FPS_WINDOW_CYC_P = FPS_WINDOW_CYC,
  parameter int unsigned RATE_UNIT_CYC_P = CLK_HZ
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  output logic cmd_ready,
  input wire logic sync_in,
  output logic proj_frame,
  output logic prev_frame,
  output logic irq
);

  typedef struct packed {
    fosp_state_type st;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [1:0] route;
    fosp_sync_mode_type mode;
    logic [31:0] delay_us;
    logic [15:0] max_fps;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic irq;
    logic [31:0] cnt;
    logic [6:0] us_pre;
    logic [31:0] rate_acc;
    logic rate_armed;
    logic [31:0] win_cnt;
    logic [15:0] frame_cnt;
    logic [15:0] fps_read;
    logic cmd_ready;
    logic proj_frame;
    logic prev_frame;
  } fosp_regs_type;

  fosp_regs_type r;
  fosp_regs_type n;
  logic sync_level;
  logic sync_rise;
  logic sync_fall;
  logic taken;
  logic hit;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [31:0] wd;
  fosp_cmd_type op;

  // ----------------------------------------------------------------
  // Sync pin front end
  // ----------------------------------------------------------------
  fosp_sync_edge u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .sync_in(sync_in),
    .level(sync_level),
    .rise(sync_rise),
    .fall(sync_fall)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    n = r;
    irq_set = 3'h0;
    irq_clr = 3'h0;
    wd = 32'h0000_0000;
    op = fosp_cmd_type'(cmd_op);
    taken = cmd_valid && r.cmd_ready;
    hit = fosp_edge_hit(r.mode, sync_rise, sync_fall);
    n.proj_frame = 1'b0;
    n.prev_frame = 1'b0;

    // Register writes: address and data may arrive in either order
    if (s_axi_awvalid && r.awready)
    begin
      n.aw_have = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready)
    begin
      n.w_have = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready)
    begin
      n.bvalid = 1'b0;
    end
    if (r.aw_have && r.w_have && !r.bvalid)
    begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      unique case (r.aw_addr)
        ADDR_ROUTE:
        begin
          wd = fosp_merge(32'(r.route), r.w_data, r.w_strb);
          n.route = wd[1:0];
        end
        ADDR_SYNC_MODE:
        begin
          wd = fosp_merge(32'(r.mode), r.w_data, r.w_strb);
          n.mode = fosp_sync_mode_type'(wd[1:0]);
        end
        ADDR_SYNC_DELAY: n.delay_us = fosp_merge(r.delay_us, r.w_data, r.w_strb);
        ADDR_MAX_FPS:
        begin
          wd = fosp_merge(32'(r.max_fps), r.w_data, r.w_strb);
          n.max_fps = wd[15:0];
        end
        ADDR_IRQ_STAT:
        begin
          wd = fosp_merge(32'h0000_0000, r.w_data, r.w_strb);
          irq_clr = wd[2:0];
        end
        ADDR_IRQ_MASK:
        begin
          wd = fosp_merge(32'(r.irq_mask), r.w_data, r.w_strb);
          n.irq_mask = wd[2:0];
        end
        ADDR_STATUS, ADDR_FPS_READ: n.bresp = RESP_OKAY;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;

    // Register reads
    if (r.rvalid && s_axi_rready)
    begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.arready)
    begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        ADDR_ROUTE: n.rdata[1:0] = r.route;
        ADDR_SYNC_MODE: n.rdata[1:0] = r.mode;
        ADDR_SYNC_DELAY: n.rdata = r.delay_us;
        ADDR_MAX_FPS: n.rdata[15:0] = r.max_fps;
        ADDR_STATUS:
        begin
          n.rdata[1:0] = r.st;
          n.rdata[STATUS_SYNC_BIT] = sync_level;
        end
        ADDR_FPS_READ: n.rdata[15:0] = r.fps_read;
        ADDR_IRQ_STAT: n.rdata[2:0] = r.irq_stat;
        ADDR_IRQ_MASK: n.rdata[2:0] = r.irq_mask;
        default: n.rresp = RESP_SLVERR;
      endcase
    end
    n.arready = !n.rvalid;

    // Rate window freezes while stalled, so inserted waits never count
    if (r.st != ST_RATE_STALL)
    begin
      if (r.win_cnt == FPS_WINDOW_CYC_P - 1)
      begin
        n.win_cnt = 32'h0000_0000;
        n.fps_read = r.frame_cnt;
        n.frame_cnt = 16'h0000;
      end
      else
      begin
        n.win_cnt = r.win_cnt + 32'h0000_0001;
      end
    end

    // Elapsed time scaled by max rate; no divider needed for the period
    if (r.rate_acc < RATE_UNIT_CYC_P)
    begin
      n.rate_acc = r.rate_acc + 32'(r.max_fps);
    end

    unique case (r.st)
      ST_IDLE:
      begin
        if (taken)
        begin
          unique case (op)
            CMD_FRAME:
            begin
              n.proj_frame = r.route[ROUTE_PROJ_BIT];
              n.prev_frame = r.route[ROUTE_PREV_BIT];
              if (r.route[ROUTE_PREV_BIT])
              begin
                n.frame_cnt = n.frame_cnt + 16'h0001;
              end
              irq_set[IRQ_FRAME_BIT] = 1'b1;
            end
            CMD_SYNC_EDGE_WAIT:
            begin
              // The wait must come right before the frame it paces
              if (r.mode != SYNC_OFF)
              begin
                n.st = ST_SYNC_WAIT;
                n.cnt = 32'h0000_0000;
              end
            end
            CMD_FRAME_RATE_CAP:
            begin
              if (r.max_fps != 16'h0000 && r.rate_armed && r.rate_acc < RATE_UNIT_CYC_P)
              begin
                n.st = ST_RATE_STALL;
                irq_set[IRQ_STALL_BIT] = 1'b1;
              end
              else
              begin
                n.rate_acc = 32'h0000_0000;
                n.rate_armed = 1'b1;
              end
            end
            CMD_OTHER: n.st = ST_IDLE;
          endcase
        end
      end
      ST_SYNC_WAIT:
      begin
        if (hit)
        begin
          n.cnt = 32'h0000_0000;
          n.us_pre = 7'h00;
          n.st = (r.delay_us == 32'h0000_0000) ? ST_IDLE : ST_SYNC_DELAY;
        end
        else if (r.cnt == SYNC_TIMEOUT_CYC_P - 1)
        begin
          n.st = ST_IDLE;
          irq_set[IRQ_TIMEOUT_BIT] = 1'b1;
        end
        else
        begin
          n.cnt = r.cnt + 32'h0000_0001;
        end
      end
      ST_SYNC_DELAY:
      begin
        if (r.us_pre == 7'(US_CYC - 1))
        begin
          n.us_pre = 7'h00;
          if (r.cnt == r.delay_us - 32'h0000_0001)
          begin
            n.st = ST_IDLE;
          end
          else
          begin
            n.cnt = r.cnt + 32'h0000_0001;
          end
        end
        else
        begin
          n.us_pre = r.us_pre + 7'h01;
        end
      end
      ST_RATE_STALL:
      begin
        // A zero cap written mid-stall ends the stall instead of hanging
        if (r.rate_acc >= RATE_UNIT_CYC_P || r.max_fps == 16'h0000)
        begin
          n.st = ST_IDLE;
          n.rate_acc = 32'h0000_0000;
        end
      end
    endcase

    n.cmd_ready = (n.st == ST_IDLE);
    // Hardware set wins over a same-cycle clear
    n.irq_stat = (r.irq_stat & ~irq_clr) | irq_set;
    n.irq = |(n.irq_stat & n.irq_mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.route <= ROUTE_RST;
      r.delay_us <= SYNC_DELAY_RST;
      r.max_fps <= MAX_FPS_RST;
      r.irq_mask <= IRQ_MASK_RST;
    end
    else
    begin
      r <= n;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bresp = r.bresp;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_arready = r.arready;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rvalid = r.rvalid;
  assign cmd_ready = r.cmd_ready;
  assign proj_frame = r.proj_frame;
  assign prev_frame = r.prev_frame;
  assign irq = r.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_frame_cmd;
    cmd_valid && r.cmd_ready && cmd_op == CMD_FRAME;
  endsequence

  sequence s_waiting_quiet;
    r.st == ST_SYNC_WAIT && r.cnt < SYNC_TIMEOUT_CYC_P - 1;
  endsequence

  a_route_frame: assert property (s_frame_cmd |=> proj_frame == $past(r.route[0]) && prev_frame == $past(r.route[1]))
    else $error("frame went to a disabled sink");
  a_other_cmd: assert property (cmd_valid && r.cmd_ready && cmd_op == CMD_OTHER |=> cmd_ready && !proj_frame && !prev_frame)
    else $error("plain command not absorbed");
  a_preview_count: assert property (s_frame_cmd ##0 r.route[1] && r.st == ST_IDLE && r.win_cnt != FPS_WINDOW_CYC_P - 1 |=> r.frame_cnt == $past(r.frame_cnt) + 16'h0001)
    else $error("preview frame not counted");
  a_rise_hold: assert property (s_waiting_quiet ##0 r.mode == WAIT_LOW_TO_HIGH && !sync_rise |=> r.st == ST_SYNC_WAIT)
    else $error("rising wait left without rise");
  a_fall_release: assert property (r.st == ST_SYNC_WAIT && r.mode == WAIT_HIGH_TO_LOW && sync_fall && r.delay_us == 32'h0000_0000 |=> cmd_ready ##1 r.st == ST_IDLE)
    else $error("falling edge did not release");
  a_any_release: assert property (r.st == ST_SYNC_WAIT && r.mode == WAIT_EITHER_TRANSITION && (sync_rise || sync_fall) |=> r.st != ST_SYNC_WAIT)
    else $error("either transition did not release");
  a_delay_follows: assert property (r.st == ST_SYNC_WAIT && hit && r.delay_us != 32'h0000_0000 |=> r.st == ST_SYNC_DELAY && !cmd_ready)
    else $error("delay after edge skipped");
  a_sync_timeout: assert property (r.st == ST_SYNC_WAIT && !hit && r.cnt == SYNC_TIMEOUT_CYC_P - 1 |=> r.st == ST_IDLE && r.irq_stat[IRQ_TIMEOUT_BIT])
    else $error("sync wait not abandoned on timeout");
  a_rate_stall: assert property (cmd_valid && r.cmd_ready && cmd_op == CMD_FRAME_RATE_CAP && r.rate_armed && r.max_fps != 16'h0000 && r.rate_acc < RATE_UNIT_CYC_P |=> r.st == ST_RATE_STALL [*2] or (r.st == ST_RATE_STALL ##1 r.st == ST_IDLE))
    else $error("short frame period not stalled");
  a_rate_default: assert property ($rose(aresetn) |-> r.max_fps == MAX_FPS_RST)
    else $error("frame cap reset value wrong");
  a_stall_excluded: assert property (r.st == ST_RATE_STALL |=> r.win_cnt == $past(r.win_cnt))
    else $error("stall time counted in rate window");

endmodule // fosp_top
`default_nettype wire

/* File: rtl/fosp_pkg.sv */
// Purpose: Shared constants, types and helpers for the frame output pacer
// Assumes: 100 MHz aclk, AXI4-Lite register access with 8-bit byte addresses
// Notes:   Offsets are byte addresses; every register is one aligned word
package fosp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_S = 1000000000;
  localparam int unsigned NS_PER_US = 1000;
  localparam int unsigned CLK_HZ = NS_PER_S / CLK_PERIOD_NS;
  localparam int unsigned US_CYC = NS_PER_US / CLK_PERIOD_NS;
  localparam int unsigned SYNC_TIMEOUT_S = 1;
  localparam int unsigned SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_S * CLK_HZ;
  localparam int unsigned FPS_WINDOW_S = 1;
  localparam int unsigned FPS_WINDOW_CYC = FPS_WINDOW_S * CLK_HZ;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ROUTE = 8'h00;
  localparam logic [7:0] ADDR_SYNC_MODE = 8'h04;
  localparam logic [7:0] ADDR_SYNC_DELAY = 8'h08;
  localparam logic [7:0] ADDR_MAX_FPS = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_FPS_READ = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;

  localparam int unsigned ROUTE_PROJ_BIT = 0;
  localparam int unsigned ROUTE_PREV_BIT = 1;
  localparam int unsigned STATUS_SYNC_BIT = 4;
  localparam int unsigned IRQ_FRAME_BIT = 0;
  localparam int unsigned IRQ_TIMEOUT_BIT = 1;
  localparam int unsigned IRQ_STALL_BIT = 2;

  localparam logic [1:0] ROUTE_RST = 2'h3;
  localparam logic [31:0] SYNC_DELAY_RST = 32'h0000_0000;
  localparam logic [15:0] MAX_FPS_RST = 16'h0064;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SYNC_OFF,
    WAIT_LOW_TO_HIGH,
    WAIT_HIGH_TO_LOW,
    WAIT_EITHER_TRANSITION
  } fosp_sync_mode_type;

  typedef enum logic [1:0] {
    CMD_OTHER,
    CMD_FRAME,
    CMD_SYNC_EDGE_WAIT,
    CMD_FRAME_RATE_CAP
  } fosp_cmd_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SYNC_WAIT,
    ST_SYNC_DELAY,
    ST_RATE_STALL
  } fosp_state_type;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] fosp_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic fosp_edge_hit(input fosp_sync_mode_type mode,
                                         input logic rise,
                                         input logic fall);
    logic hit;
    hit = 1'b0;
    unique case (mode)
      SYNC_OFF: hit = 1'b1;
      WAIT_LOW_TO_HIGH: hit = rise;
      WAIT_HIGH_TO_LOW: hit = fall;
      WAIT_EITHER_TRANSITION: hit = rise | fall;
    endcase
    return hit;
  endfunction

endpackage

/* File: rtl/fosp_sync_edge.sv */
// Purpose: Bring the external sync pin into aclk and flag its edges
// Assumes: sync_in is asynchronous to aclk
// Notes:   Edge pulses are one cycle and registered
`timescale 1ns/1ps
`default_nettype none
module fosp_sync_edge
  import fosp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sync_in,
  output logic level,
  output logic rise,
  output logic fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic primed;
    logic lvl;
    logic rise;
    logic fall;
  } fosp_se_type;

  fosp_se_type r;
  fosp_se_type n;

  // ----------------------------------------------------------------
  // Synchroniser and edge compare
  // ----------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.s1 = sync_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.rise = 1'b0;
    n.fall = 1'b0;
    // First agreement only loads the level, but it sees the reset-cleared 0s, so a high pin at reset still gives a rise
    if (r.s2 == r.s3 && (!r.primed || r.s3 != r.lvl))
    begin
      n.primed = 1'b1;
      n.lvl = r.s3;
      n.rise = r.primed & r.s3;
      n.fall = r.primed & !r.s3;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign level = r.lvl;
  assign rise = r.rise;
  assign fall = r.fall;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_edge_from_level: assert property ((r.rise || r.fall) |-> r.lvl != $past(r.lvl))
    else $error("sync edge without level change");

endmodule // fosp_sync_edge
`default_nettype wire

/* File: tb/fosp_far_model.sv */
// Purpose: Sync source and frame sinks on the far side of the pacer
// Assumes: Sync pin is asynchronous to aclk, no pull on it
// Notes:   Frame pulses are counted per sink for the bench
`timescale 1ns/1ps
`default_nettype none
module fosp_far_model
(
  input wire logic aclk,
  input wire logic sync_req,
  input wire logic proj_frame,
  input wire logic prev_frame,
  output var logic sync_in,
  output var logic [15:0] proj_cnt,
  output var logic [15:0] prev_cnt
);
  // ----------------------------------------------------------------
  // Sync pin and sinks
  // ----------------------------------------------------------------
  // Pin moves 3 ns off the clock edge so the synchroniser sees a real async change
  initial sync_in = 1'h0;
  always @(sync_req) sync_in <= #3 sync_req;
  initial proj_cnt = 16'h0000;
  initial prev_cnt = 16'h0000;
  always @(posedge aclk)
  begin
    if (proj_frame)
      proj_cnt <= proj_cnt + 16'h0001;
    if (prev_frame)
      prev_cnt <= prev_cnt + 16'h0001;
  end
endmodule // fosp_far_model
`default_nettype wire

/* File: tb/fosp_top_tb.sv */
// Purpose: Self-checking bench for the frame output pacer
// Assumes: Shortened timeout, fps window and rate unit parameters
// Notes:   Every wait is bounded; registers reached over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module fosp_top_tb;
  import fosp_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int TO_P = 200;
  localparam int RU_P = 1000;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'h0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'h0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'h0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'h0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'h0;
  logic cmd_valid = 1'h0;
  logic [1:0] cmd_op = 2'h0;
  logic cmd_ready;
  logic sync_req = 1'h0;
  logic sync_in;
  logic proj_frame;
  logic prev_frame;
  logic irq;
  logic [15:0] proj_cnt;
  logic [15:0] prev_cnt;
  int n_errors = 0;
  int n_compared = 0;

  fosp_top #(.SYNC_TIMEOUT_CYC_P(TO_P), .FPS_WINDOW_CYC_P(100), .RATE_UNIT_CYC_P(RU_P)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready), .sync_in(sync_in),
    .proj_frame(proj_frame), .prev_frame(prev_frame), .irq(irq));

  fosp_far_model far_u (.aclk(aclk), .sync_req(sync_req), .proj_frame(proj_frame),
    .prev_frame(prev_frame), .sync_in(sync_in), .proj_cnt(proj_cnt), .prev_cnt(prev_cnt));

  always #5 aclk = ~aclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic fail_wait;
    n_errors++;
    $display("ERROR t=%0t wait bound used up got=%h exp=%h", $time, 0, 1);
    end_of_test();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int k = 0; k < 50; k++)
    begin
      @(posedge aclk);
      if (!awvalid && !wvalid && bvalid)
      begin
        bready <= 1'h0;
        chk(32'(bresp), 32'(er));
        return;
      end
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    fail_wait();
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int k = 0; k < 50; k++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'h0;
      if (!arvalid && rvalid)
      begin
        rready <= 1'h0;
        chk(rdata, exp);
        chk(32'(rresp), 32'(er));
        return;
      end
    end
    fail_wait();
  endtask

  // Extra edge after release keeps cmd_valid from being set twice in one step
  task automatic send(input logic [1:0] op);
    cmd_op <= op;
    cmd_valid <= 1'h1;
    for (int k = 0; k < 2000; k++)
    begin
      @(posedge aclk);
      if (cmd_ready)
      begin
        cmd_valid <= 1'h0;
        @(posedge aclk);
        return;
      end
    end
    fail_wait();
  endtask

  task automatic wait_rdy(output int n);
    for (n = 1; n < 2000; n++)
    begin
      @(posedge aclk);
      if (cmd_ready)
        return;
    end
    fail_wait();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rdc(ADDR_ROUTE, 32'h0000_0003, RESP_OKAY);
    rdc(ADDR_SYNC_MODE, 32'h0, RESP_OKAY);
    rdc(ADDR_SYNC_DELAY, 32'h0, RESP_OKAY);
    rdc(ADDR_MAX_FPS, 32'h0000_0064, RESP_OKAY);
    rdc(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
    rdc(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(ADDR_FPS_READ, 32'h0000_1234, RESP_OKAY);
    rdc(ADDR_FPS_READ, 32'h0, RESP_OKAY);
    $display("register test done");
  endtask

  task automatic t_route;
    logic [15:0] p0;
    logic [15:0] q0;
    for (int r = 0; r < 4; r++)
    begin
      wr(ADDR_ROUTE, 32'(r), RESP_OKAY);
      wr(ADDR_IRQ_STAT, 32'h7, RESP_OKAY);
      p0 = proj_cnt;
      q0 = prev_cnt;
      send(CMD_FRAME);
      repeat (2) @(posedge aclk);
      chk(32'(proj_cnt - p0), 32'(r & 1));
      chk(32'(prev_cnt - q0), 32'(r >> 1));
      rdc(ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
    end
    // Route is 3 here; a plain command must pass with no frame and no stall
    p0 = proj_cnt;
    q0 = prev_cnt;
    send(CMD_OTHER);
    chk(32'(cmd_ready), 32'h1);
    repeat (2) @(posedge aclk);
    chk(32'(proj_cnt - p0), 32'h0);
    chk(32'(prev_cnt - q0), 32'h0);
    // Sync mode is still off, so a wait command must not hold the port
    send(CMD_SYNC_EDGE_WAIT);
    chk(32'(cmd_ready), 32'h1);
    $display("route test done");
  endtask

  task automatic t_irq;
    wr(ADDR_IRQ_MASK, 32'h1, RESP_OKAY);
    send(CMD_FRAME);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h1);
    wr(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    wr(ADDR_IRQ_MASK, 32'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h1);
    wr(ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    $display("irq test done");
  endtask

  // Wrong-direction change first in modes 1 and 2 (none in mode 3), so an edge-polarity slip releases early
  task automatic t_sync(input logic [1:0] m);
    int n;
    wr(ADDR_SYNC_MODE, 32'(m), RESP_OKAY);
    sync_req <= (m == 2'h1);
    repeat (10) @(posedge aclk);
    send(CMD_SYNC_EDGE_WAIT);
    if (m != 2'h3)
    begin
      sync_req <= ~sync_req;
      repeat (20) @(posedge aclk);
      chk(32'(cmd_ready), 32'h0);
    end
    sync_req <= ~sync_req;
    wait_rdy(n);
    chk_rng(n, 3, 12);
    send(CMD_FRAME);
    $display("sync mode %0d test done", m);
  endtask

  task automatic t_delay_timeout;
    int n;
    wr(ADDR_SYNC_MODE, 32'h3, RESP_OKAY);
    wr(ADDR_SYNC_DELAY, 32'h1, RESP_OKAY);
    send(CMD_SYNC_EDGE_WAIT);
    sync_req <= ~sync_req;
    wait_rdy(n);
    chk_rng(n, 100, 115);
    wr(ADDR_SYNC_DELAY, 32'h0, RESP_OKAY);
    wr(ADDR_SYNC_MODE, 32'h1, RESP_OKAY);
    wr(ADDR_IRQ_STAT, 32'h7, RESP_OKAY);
    send(CMD_SYNC_EDGE_WAIT);
    wait_rdy(n);
    chk_rng(n, TO_P - 5, TO_P + 5);
    rdc(ADDR_IRQ_STAT, 32'h2, RESP_OKAY);
    $display("delay and timeout test done");
  endtask

  task automatic t_rate;
    int n;
    int fps [2] = '{100, 50};
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_MAX_FPS, 32'(fps[i]), RESP_OKAY);
      wr(ADDR_IRQ_STAT, 32'h7, RESP_OKAY);
      repeat (30) @(posedge aclk);
      send(CMD_FRAME_RATE_CAP);
      wait_rdy(n);
      chk_rng(n, 1, 1);
      send(CMD_FRAME_RATE_CAP);
      wait_rdy(n);
      chk_rng(n, RU_P / fps[i] - 6, RU_P / fps[i]);
      rdc(ADDR_IRQ_STAT, 32'h4, RESP_OKAY);
    end
    wr(ADDR_MAX_FPS, 32'h0, RESP_OKAY);
    send(CMD_FRAME_RATE_CAP);
    send(CMD_FRAME_RATE_CAP);
    wait_rdy(n);
    chk_rng(n, 1, 1);
    $display("rate test done");
  endtask

  task automatic t_fps;
    wr(ADDR_ROUTE, 32'h1, RESP_OKAY);
    repeat (5) send(CMD_FRAME);
    repeat (150) @(posedge aclk);
    rdc(ADDR_FPS_READ, 32'h0, RESP_OKAY);
    $display("fps test done");
  endtask

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_route();
    t_irq();
    t_sync(2'h1);
    t_sync(2'h2);
    t_sync(2'h3);
    t_delay_timeout();
    t_rate();
    t_fps();
    end_of_test();
  end
endmodule // fosp_top_tb
`default_nettype wire
